// *** rtl/pcrc_top.sv ***
// programmable crc engine: apb registers, input fifo and two-bit-per-cycle shifter
// assumes apb master on pclk; idle_mode is a synchronous level from the chip
// Contract
// - module_on low clears fsm, fifo, data input pair, result pair and run bit only
// - idle_halt_select set stops operation while chip idle
// - five-bit read-only fifo_word_count shows valid words
// - count saturates at fifo depth for the configured width
// - fifo_full_flag reads one exactly at maximum count
// - fifo_empty_flag reads one with no words; resets to one
// - count, full and empty are hardware-only; writes ignored
// - irq_source_select one: interrupt when fifo becomes empty
// - irq_source_select zero: interrupt when shifting done, result ready
// - software sets shifter_run; hardware clears it when finished
// - shifter_run zero keeps shifter stopped, no words consumed; a word popped before a software clear still shifts to its end
// - lsb_first_select one feeds words lsb first
// - lsb_first_select zero feeds words msb first
// - data_width_minus_one field in control two sets word width
// - poly_length_minus_one field in control two sets polynomial length
// - poly_mask_low holds terms 15..1; bit 0 reads zero
// - poly_mask_high holds terms 31..16
// - fifo depth 4, 8 or 16 words by data width
// - count increments on write of the word's top byte
// - shifting starts with run set and words present; pop decrements count
// - two data bits per cycle
//
// Chosen here: the register offsets and the APB interface to the registers.
module pcrc_top
   import pcrc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        idle_mode,
   output logic             crc_irq
);
   import pcrc_pkg::*;

   pcrc_cfg_t   cfg_q;
   logic        run_q;
   logic [15:0] xorl_q;
   logic [15:0] xorh_q;
   logic [15:0] datl_q;
   logic [15:0] dath_q;
   logic [31:0] res_q;
   logic [31:0] fifo_q [FIFO_WORDS];
   logic [3:0]  wr_ptr_q;
   logic [3:0]  rd_ptr_q;
   logic [4:0]  cnt_q;
   logic [31:0] buf_q;
   logic [5:0]  left_q;
   pcrc_state_t st_q;

   logic        acc;
   logic        wr;
   logic        active;
   logic [4:0]  depth;
   logic        push;
   logic        pop;
   logic        full;
   logic        done;
   logic [31:0] in_word;
   logic [31:0] res_d;
   logic [31:0] buf_d;
   logic [1:0]  top_lane;
   logic [31:0] len_mask;

   // top byte index of the configured word: the push trigger
   function automatic logic [1:0] top_byte(input logic [4:0] w);
      return w[4:3];
   endfunction

   assign acc    = psel & penable;
   assign wr     = acc & pwrite;
   assign active = cfg_q.module_on & ~(cfg_q.idle_halt_select & idle_mode);
   always_comb begin
      if (cfg_q.data_width_minus_one > W_BIG) begin
         depth = DEPTH_4;
      end else if (cfg_q.data_width_minus_one > W_SMALL) begin
         depth = DEPTH_8;
      end else begin
         depth = DEPTH_16;
      end
   end
   assign full = (cnt_q >= depth);
   assign top_lane = top_byte(cfg_q.data_width_minus_one);
   // bits above the polynomial length stay clear so the high result half reads clean
   assign len_mask = {32{1'b1}} >> (~cfg_q.poly_length_minus_one);
   // word pushes when the lane holding its top byte is written; low half must go first
   always_comb begin
      push = 1'b0;
      if (wr && active && !full) begin
         if (top_lane[1]) begin
            push = (paddr == OFS_DATH) && pstrb[top_lane[0]];
         end else begin
            push = (paddr == OFS_DATL) && pstrb[top_lane[0]];
         end
      end
   end
   assign in_word = {dath_q, datl_q};
   assign pop  = active && run_q && (cnt_q != 5'h00)
               && ((st_q == SH_IDLE) || (left_q <= BITS_PER_CYC));
   assign done = active && (st_q == SH_SHIFT) && (left_q <= BITS_PER_CYC) && !pop;

   // apb answers in the access cycle; no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               OFS_CON1: prdata <= {16'h0000, cfg_q.module_on, 1'b0, cfg_q.idle_halt_select,
                                    cnt_q, full, cnt_q == 5'h00, cfg_q.irq_source_select,
                                    run_q, cfg_q.lsb_first_select, 3'h0};
               OFS_CON2: prdata <= {16'h0000, 3'h0, cfg_q.data_width_minus_one,
                                    3'h0, cfg_q.poly_length_minus_one};
               OFS_XORL: prdata <= {16'h0000, xorl_q};
               OFS_XORH: prdata <= {16'h0000, xorh_q};
               OFS_DATL: prdata <= {16'h0000, datl_q};
               OFS_DATH: prdata <= {16'h0000, dath_q};
               OFS_RESL: prdata <= {16'h0000, res_q[15:0]};
               OFS_RESH: prdata <= {16'h0000, res_q[31:16]};
               default:  prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control registers survive module_on low; only count/full/empty are not writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q  <= '0;
         xorl_q <= 16'h0000;
         xorh_q <= 16'h0000;
      end else if (wr && pready) begin
         if (paddr == OFS_CON1) begin
            cfg_q.module_on         <= pwdata[B_ON];
            cfg_q.idle_halt_select  <= pwdata[B_IDLE];
            cfg_q.irq_source_select <= pwdata[B_ISEL];
            cfg_q.lsb_first_select  <= pwdata[B_LSB];
         end
         if (paddr == OFS_CON2) begin
            cfg_q.data_width_minus_one  <= pwdata[B_DW_LO +: 5];
            cfg_q.poly_length_minus_one <= pwdata[4:0];
         end
         if (paddr == OFS_XORL) begin
            xorl_q <= pwdata[15:0] & XORL_MASK;
         end
         if (paddr == OFS_XORH) begin
            xorh_q <= pwdata[15:0];
         end
      end
   end

   // run bit: software write, hardware clear when the last word finishes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
      end else if (!cfg_q.module_on) begin
         run_q <= 1'b0;
      end else if (wr && pready && paddr == OFS_CON1) begin
         run_q <= pwdata[B_RUN];
      end else if (done && cnt_q == 5'h00) begin
         run_q <= 1'b0;
      end
   end

   // data input pair latches the whole low half of pwdata, strobes ignored; the push takes the merged word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         datl_q <= 16'h0000;
         dath_q <= 16'h0000;
      end else if (!cfg_q.module_on) begin
         datl_q <= 16'h0000;
         dath_q <= 16'h0000;
      end else if (wr && pready && paddr == OFS_DATL) begin
         datl_q <= pwdata[15:0];
      end else if (wr && pready && paddr == OFS_DATH) begin
         dath_q <= pwdata[15:0];
      end
   end

   // push lands at the access edge; the stored word merges pwdata with the held half
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_q <= 4'h0;
         rd_ptr_q <= 4'h0;
         cnt_q    <= 5'h00;
      end else if (!cfg_q.module_on) begin
         wr_ptr_q <= 4'h0;
         rd_ptr_q <= 4'h0;
         cnt_q    <= 5'h00;
      end else begin
         if (push && pready) begin
            wr_ptr_q <= wr_ptr_q + 4'h1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 4'h1;
         end
         if ((push && pready) && !pop) begin
            cnt_q <= cnt_q + 5'h01;
         end else if (pop && !(push && pready)) begin
            cnt_q <= cnt_q - 5'h01;
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (push && pready) begin
         fifo_q[wr_ptr_q] <= (paddr == OFS_DATH) ? {pwdata[15:0], datl_q}
                                                  : {dath_q, pwdata[15:0]};
      end
   end

   // two crc steps per cycle; feed bit taken from the buffer's leading end
   always_comb begin
      logic fb;
      fb    = 1'b0;
      res_d = res_q;
      buf_d = buf_q;
      for (int i = 0; i < int'(BITS_PER_CYC); i++) begin
         fb = 1'b0;
         if (left_q > 6'(i)) begin
            if (cfg_q.lsb_first_select) begin
               fb = buf_d[0] ^ res_d[cfg_q.poly_length_minus_one];
               buf_d = buf_d >> 1;
            end else begin
               fb = buf_d[cfg_q.data_width_minus_one] ^ res_d[cfg_q.poly_length_minus_one];
               buf_d = buf_d << 1;
            end
            res_d = (res_d << 1) ^ ({32{fb}} & {xorh_q, xorl_q[15:1], 1'b1});
         end
      end
      res_d = res_d & len_mask;
   end

   // the shift path keeps running while software loads a start value; the result step of that cycle is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q   <= SH_IDLE;
         buf_q  <= 32'h0000_0000;
         left_q <= 6'h00;
      end else if (!cfg_q.module_on) begin
         st_q   <= SH_IDLE;
         buf_q  <= 32'h0000_0000;
         left_q <= 6'h00;
      end else if (active) begin
         if (pop) begin
            buf_q  <= fifo_q[rd_ptr_q];
            left_q <= {1'b0, cfg_q.data_width_minus_one} + 6'h01;
            st_q   <= SH_SHIFT;
         end else if (st_q == SH_SHIFT) begin
            buf_q  <= buf_d;
            left_q <= (left_q <= BITS_PER_CYC) ? 6'h00 : left_q - BITS_PER_CYC;
            if (left_q <= BITS_PER_CYC) begin
               st_q <= SH_IDLE;
            end
         end
      end
   end

   // a software write to the result pair wins over the shift step of that cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_q <= 32'h0000_0000;
      end else if (!cfg_q.module_on) begin
         res_q <= 32'h0000_0000;
      end else if (wr && pready && paddr == OFS_RESL) begin
         res_q[15:0] <= pwdata[15:0];
      end else if (wr && pready && paddr == OFS_RESH) begin
         res_q[31:16] <= pwdata[15:0];
      end else if (active && st_q == SH_SHIFT) begin
         res_q <= res_d;
      end
   end

   // interrupt pulses once per event; a software clear of run is not an event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_irq <= 1'b0;
      end else if (cfg_q.irq_source_select) begin
         crc_irq <= pop && cnt_q == 5'h01 && !(push && pready);
      end else begin
         crc_irq <= done && cnt_q == 5'h00 && run_q;
      end
   end

   // steps of an interrupt event, shared by the pulse and source checks
   sequence s_irq_once;
      crc_irq ##1 !crc_irq;
   endsequence
   sequence s_last_pop;
      cfg_q.irq_source_select && pop && cnt_q == 5'h01 && !push;
   endsequence

   a_empty_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg_q.module_on |=> cnt_q == 5'h00)
      else $error("count not cleared while off");
   a_count_sat: assert property (@(posedge pclk) disable iff (!presetn)
      cnt_q > $past(cnt_q) |-> cnt_q <= depth)
      else $error("count above depth");
   a_stopped_run: assert property (@(posedge pclk) disable iff (!presetn)
      !run_q |-> !pop)
      else $error("pop without run");
   a_pop_dec: assert property (@(posedge pclk) disable iff (!presetn)
      pop && !push && cfg_q.module_on && !(wr && paddr == OFS_CON1)
      |=> cnt_q == $past(cnt_q) - 5'h01)
      else $error("pop did not decrement");
   a_irq_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      crc_irq |-> s_irq_once)
      else $error("irq longer than one cycle");
   a_shift_rate: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == SH_SHIFT && active && !pop && left_q > BITS_PER_CYC
      |=> left_q == $past(left_q) - BITS_PER_CYC)
      else $error("shift rate wrong");
   a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn)
      cfg_q.idle_halt_select && idle_mode && cfg_q.module_on && !(wr && paddr == OFS_CON1)
      |=> $stable(left_q) && $stable(rd_ptr_q))
      else $error("ran during idle");
   a_mask_low: assert property (@(posedge pclk) disable iff (!presetn)
      xorl_q[0] == 1'b0)
      else $error("mask bit zero set");
   a_empty_irq: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_pop |=> crc_irq)
      else $error("no interrupt on fifo empty");
   a_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg_q.irq_source_select && done && cnt_q == 5'h00 && run_q |=> crc_irq)
      else $error("no interrupt on shift done");
   a_run_clear: assert property (@(posedge pclk) disable iff (!presetn)
      done && cnt_q == 5'h00 && cfg_q.module_on && !(wr && paddr == OFS_CON1) |=> !run_q)
      else $error("run not cleared when finished");
   a_off_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg_q.module_on |=> st_q == SH_IDLE && left_q == 6'h00 && res_q == 32'h0000_0000)
      else $error("shifter not cleared while off");
endmodule

// *** rtl/pcrc_pkg.sv ***
// constants, register map and field layout for the programmable crc engine
// assumes an apb slave with 32-bit data; registers are 16 bits in the low half
package pcrc_pkg;
   localparam logic [7:0] OFS_CON1   = 8'h00;
   localparam logic [7:0] OFS_CON2   = 8'h04;
   localparam logic [7:0] OFS_XORL   = 8'h08;
   localparam logic [7:0] OFS_XORH   = 8'h0c;
   localparam logic [7:0] OFS_DATL   = 8'h10;
   localparam logic [7:0] OFS_DATH   = 8'h14;
   localparam logic [7:0] OFS_RESL   = 8'h18;
   localparam logic [7:0] OFS_RESH   = 8'h1c;
   localparam int B_ON     = 15;
   localparam int B_IDLE   = 13;
   localparam int B_CNT_LO = 8;
   localparam int B_FULL   = 7;
   localparam int B_EMPTY  = 6;
   localparam int B_ISEL   = 5;
   localparam int B_RUN    = 4;
   localparam int B_LSB    = 3;
   localparam int B_DW_LO  = 8;
   localparam logic [15:0] XORL_MASK = 16'hfffe;
   localparam logic [4:0]  W_BIG     = 5'h0f;
   localparam logic [4:0]  W_SMALL   = 5'h07;
   localparam logic [4:0]  DEPTH_4   = 5'h04;
   localparam logic [4:0]  DEPTH_8   = 5'h08;
   localparam logic [4:0]  DEPTH_16  = 5'h10;
   localparam int          FIFO_WORDS = 16;
   localparam logic [5:0]  BITS_PER_CYC = 6'h02;
   typedef struct packed {
      logic        module_on;
      logic        idle_halt_select;
      logic        irq_source_select;
      logic        lsb_first_select;
      logic [4:0]  data_width_minus_one;
      logic [4:0]  poly_length_minus_one;
   } pcrc_cfg_t;
   typedef enum logic [1:0] {
      SH_IDLE  = 2'b01,
      SH_SHIFT = 2'b10
   } pcrc_state_t;
endpackage

// *** test/pcrc_tb.sv ***
// self-checking bench for the programmable crc engine: apb tasks and directed sequences
// assumes pcrc_top answers every apb access in one access cycle and pulses crc_irq
module testbench import pcrc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ON  = 32'h0000_8000;
   localparam logic [31:0] IDL = 32'h0000_2000;
   localparam logic [31:0] ISL = 32'h0000_0020;
   localparam logic [31:0] RUN = 32'h0000_0010;
   localparam logic [31:0] LSB = 32'h0000_0008;
   localparam logic [31:0] EMP = 32'h0000_0040;
   localparam logic [31:0] FUL = 32'h0000_0080;
   logic        pclk, presetn, psel, penable, pwrite, idle_mode;
   logic        pready, pslverr, crc_irq, re;
   logic [7:0]  paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, rd, r1;
   logic [4:0]  dws [3] = '{5'h1f, 5'h0f, 5'h07};
   int          dep [3] = '{4, 8, 16};
   int          miscompares, checked, irq_n, n;

   pcrc_top i_pcrc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .crc_irq(crc_irq));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // counts high cycles, so a stretched pulse shows up as extra events
   always @(posedge pclk) if (crc_irq === 1'b1) irq_n <= irq_n + 1;

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         miscompares++;
         complete_run();
      end
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   // low half first, the high half only where the word's top byte lives there
   task automatic push(input logic [31:0] d, input logic hi);
      apb(1'b1, OFS_DATL, {16'h0, d[15:0]});
      if (hi) apb(1'b1, OFS_DATH, {16'h0, d[31:16]});
   endtask

   task automatic wait_irq();
      int s;
      s = irq_n;
      n = 0;
      while (irq_n == s && n < 300) begin
         @(posedge pclk);
         n++;
      end
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      complete_run();
   end

   initial begin
      {psel, penable, pwrite, idle_mode, presetn} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc("con1 reset", OFS_CON1, EMP);
      apb(1'b1, OFS_CON1, 32'h0000_1fc0);
      rdc("status ro", OFS_CON1, EMP);
      apb(1'b1, OFS_XORL, 32'h0000_ffff);
      rdc("xor low", OFS_XORL, 32'h0000_fffe);
      apb(1'b1, OFS_XORH, 32'h0000_a5c3);
      rdc("xor high", OFS_XORH, 32'h0000_a5c3);
      rdc("unmapped", 8'h24, 32'h0);
      chk("slverr", 32'h0, {31'h0, re});
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, OFS_CON1, ON);
         apb(1'b1, OFS_CON2, {19'h0, dws[i], 8'h0f});
         for (int j = 0; j < dep[i]; j++) push(32'h0101_0101 * j, dws[i] == 5'h1f);
         rdc("full", OFS_CON1, ON | FUL | (32'(dep[i]) << 8));
         push(32'h1234_5678, dws[i] == 5'h1f);
         rdc("saturate", OFS_CON1, ON | FUL | (32'(dep[i]) << 8));
         apb(1'b1, OFS_CON1, 32'h0);
         rdc("off clears", OFS_CON1, EMP);
         rdc("con2 kept", OFS_CON2, {19'h0, dws[i], 8'h0f});
      end
      apb(1'b1, OFS_CON2, 32'h0000_1f0f);
      apb(1'b1, OFS_CON1, ON);
      apb(1'b1, OFS_DATL, 32'h0000_5555);
      rdc("low half", OFS_CON1, ON | EMP);
      apb(1'b1, OFS_DATH, 32'h0000_aaaa);
      rdc("high half", OFS_CON1, ON | 32'h0100);
      repeat (40) @(posedge pclk);
      rdc("stopped", OFS_CON1, ON | 32'h0100);
      idle_mode <= 1'b1;
      apb(1'b1, OFS_CON1, ON | IDL | RUN);
      repeat (40) @(posedge pclk);
      rdc("idle halt", OFS_CON1, ON | IDL | RUN | 32'h0100);
      idle_mode <= 1'b0;
      wait_irq();
      chk("resume irq", 1, n < 300);
      rdc("run cleared", OFS_CON1, ON | IDL | EMP);
      push(32'hdead_beef, 1'b1);
      apb(1'b1, OFS_CON1, ON | RUN);
      wait_irq();
      chk("shift time", 1, n >= 16 && n <= 22);
      push(32'hcafe_f00d, 1'b1);
      apb(1'b1, OFS_CON1, ON | ISL | RUN);
      wait_irq();
      chk("empty irq", 1, n < 14);
      repeat (30) @(posedge pclk);
      rdc("done", OFS_CON1, ON | ISL | EMP);
      chk("irq pulses", 3, irq_n);
      push(32'h0000_0001, 1'b1);
      apb(1'b1, OFS_CON1, ON | RUN);
      apb(1'b1, OFS_CON1, ON);
      repeat (30) @(posedge pclk);
      chk("sw clear", 3, irq_n);
      apb(1'b1, OFS_RESL, 32'h0000_1234);
      rdc("result", OFS_RESL, 32'h0000_1234);
      apb(1'b1, OFS_CON1, 32'h0);
      rdc("result off", OFS_RESL, 32'h0);
      apb(1'b1, OFS_CON2, 32'h0000_070f);
      apb(1'b1, OFS_XORL, 32'h0000_1021);
      // 0x80 msb first and 0x01 lsb first feed the same bit stream
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, OFS_CON1, ON);
         push(k ? 32'h01 : 32'h80, 1'b0);
         apb(1'b1, OFS_CON1, ON | RUN | (k ? LSB : 32'h0));
         wait_irq();
         apb(1'b0, OFS_RESL, 32'h0);
         if (k == 0) r1 = rd;
         else chk("bit order", r1, rd);
         apb(1'b1, OFS_CON1, 32'h0);
      end
      chk("crc value", 32'h0000_9188, r1);
      complete_run();
   end
endmodule
